/* rtl/clock_watchdog.sv */
`timescale 1ns/1ns
`default_nettype none

module clock_watchdog #(
  parameter int IDLE_CYCLES = 250
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic osc_tick_i,
  input  wire logic osc_range_fault_i,
  output var  logic clock_error_o
);

  // ************************************************************
  // Activity watchdog
  // ************************************************************
  localparam int CW = $clog2(IDLE_CYCLES + 1);

  logic [CW-1:0] idle_count;

  generate
    if (IDLE_CYCLES < 2)
    begin : g_bad_idle
      $error("clock_watchdog: IDLE_CYCLES must be at least 2");
    end
  endgenerate

  // Count cycles with no tick from the oscillator monitor
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      idle_count <= '0;
    else if (osc_tick_i)
      idle_count <= '0;
    else if (idle_count != CW'(IDLE_CYCLES))
      idle_count <= idle_count + CW'(1);
  end

  // Sticky error, only a power-on reset removes it
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      clock_error_o <= 1'b0;
    else if (osc_range_fault_i || idle_count == CW'(IDLE_CYCLES))
      clock_error_o <= 1'b1;
  end

  chk_clock_error_sticky : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    clock_error_o |=> clock_error_o)
    else $error("clock error dropped without reset");

  chk_clock_idle_limit : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (idle_count == CW'(IDLE_CYCLES)) |=> clock_error_o)
    else $error("idle clock not reported");

endmodule : clock_watchdog
`default_nettype wire

/* rtl/fault_flag_mask_unit.sv */
`timescale 1ns/1ns
`default_nettype none

module fault_flag_mask_unit #(
  parameter int CHANNELS    = 6,
  parameter int IDLE_CYCLES = fault_flag_pkg::CLOCK_IDLE_CYCLES
) (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // Register port from the serial management interface
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_rd_i,
  output var  logic [7:0]          reg_rdata_o,
  // Analog detector levels, asynchronous
  input  wire logic [CHANNELS-1:0] shorted_string_det_i,
  input  wire logic                timing_resistor_det_i,
  input  wire logic                current_set_gnd_det_i,
  input  wire logic                reference_current_det_i,
  input  wire logic                boost_low_voltage_det_i,
  input  wire logic                boost_high_voltage_det_i,
  input  wire logic                thermal_warning_det_i,
  input  wire logic                thermal_shutdown_det_i,
  input  wire logic                osc_tick_i,
  input  wire logic                osc_range_det_i,
  // Flag summaries from neighbouring diagnostic logic, same clock
  input  wire logic                open_string_fault_i,
  input  wire logic                ground_short_fault_i,
  input  wire logic                on_time_mismatch_i,
  input  wire logic                parity_error_i,
  input  wire logic                supply_low_voltage_i,
  input  wire logic                current_mismatch_i,
  // Outputs
  output var  logic                fault_out_n_o,
  output var  logic                operation_halt_o,
  output var  logic                boost_disable_o
);

  import fault_flag_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  localparam int NSYNC = CHANNELS + 9;

  logic [NSYNC-1:0]    sync_meta;
  logic [NSYNC-1:0]    sync_out;
  logic [CHANNELS-1:0] short_det;
  logic                rt_det;
  logic                iset_det;
  logic                reference_current_det;
  logic                buv_det;
  logic                bov_det;
  logic                otw_det;
  logic                ot_det;
  logic                osc_range_det;
  logic [CHANNELS-1:0] shorted_string_flags;
  logic [7:0]          fault_pin_mask_a;
  logic [7:0]          fault_pin_mask_b;
  logic [7:0]          core_diagnostic_status;
  logic [7:0]          next_diag;
  logic                clock_error;
  logic                rd_short;
  logic                rd_diag;
  logic                any_unmasked;
  logic                iset_latched;

  generate
    if (CHANNELS < 1 || CHANNELS > 8)
    begin : g_bad_channels
      $error("fault_flag_mask_unit: CHANNELS must be 1 to 8");
    end
  endgenerate

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Two flops; only the second stage feeds the logic
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync_meta <= '0;
      sync_out  <= '0;
    end
    else
    begin
      sync_meta <= {osc_range_det_i, thermal_shutdown_det_i,
                    thermal_warning_det_i, boost_high_voltage_det_i,
                    boost_low_voltage_det_i, reference_current_det_i,
                    current_set_gnd_det_i, timing_resistor_det_i,
                    osc_tick_i, shorted_string_det_i};
      sync_out  <= sync_meta;
    end
  end

  assign short_det     = sync_out[CHANNELS-1:0];
  assign rt_det        = sync_out[CHANNELS+1];
  assign iset_det      = sync_out[CHANNELS+2];
  assign reference_current_det      = sync_out[CHANNELS+3];
  assign buv_det       = sync_out[CHANNELS+4];
  assign bov_det       = sync_out[CHANNELS+5];
  assign otw_det       = sync_out[CHANNELS+6];
  assign ot_det        = sync_out[CHANNELS+7];
  assign osc_range_det = sync_out[CHANNELS+8];

  assign rd_short = reg_rd_i && reg_addr_i == ADDR_SHORTED_STRING_FLAGS;
  assign rd_diag  = reg_rd_i && reg_addr_i == ADDR_CORE_DIAGNOSTIC_STATUS;

  // ************************************************************
  // Clock watchdog
  // ************************************************************
  clock_watchdog #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_clock_watchdog (
    .clk_i             (clk_i),
    .arst_n_i          (arst_n_i),
    .osc_tick_i        (sync_out[CHANNELS]),
    .osc_range_fault_i (osc_range_det),
    .clock_error_o     (clock_error)
  );

  // ************************************************************
  // Shorted-string flags
  // ************************************************************
  // Detection in the read cycle wins so no event is lost
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_short
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          shorted_string_flags[ch] <= SHORTED_RESET[ch];
        else if (short_det[ch])
          shorted_string_flags[ch] <= 1'b1;
        else if (rd_short)
          shorted_string_flags[ch] <= 1'b0;
      end
    end
  endgenerate

  // ************************************************************
  // Mask registers
  // ************************************************************
  // Unused and reserved bits stay zero whatever is written
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fault_pin_mask_a <= MASK_A_RESET;
      fault_pin_mask_b <= MASK_B_RESET;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == ADDR_FAULT_PIN_MASK_A)
        fault_pin_mask_a <= reg_wdata_i & MASK_A_WRITABLE;
      if (reg_addr_i == ADDR_FAULT_PIN_MASK_B)
        fault_pin_mask_b <= reg_wdata_i & MASK_B_WRITABLE;
    end
  end

  // ************************************************************
  // Core diagnostic register
  // ************************************************************
  // Read clears all but the current-set bit; new detection wins
  always_comb
  begin
    next_diag = rd_diag ? (core_diagnostic_status
                           & (8'h01 << DG_CURRENT_SET_GND))
                        : core_diagnostic_status;
    if (rd_diag)
      next_diag[DG_POWER_UP] = 1'b0;
    if (rt_det)
      next_diag[DG_TIMING_RESISTOR] = 1'b1;
    if (iset_det)
      next_diag[DG_CURRENT_SET_GND] = 1'b1;
    if (reference_current_det)
      next_diag[DG_REFERENCE_RANGE] = 1'b1;
    if (buv_det)
      next_diag[DG_BOOST_LOW] = 1'b1;
    if (bov_det)
      next_diag[DG_BOOST_HIGH] = 1'b1;
    if (otw_det)
      next_diag[DG_THERMAL_WARN] = 1'b1;
    if (ot_det)
      next_diag[DG_THERMAL_SHUTDOWN] = 1'b1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      core_diagnostic_status <= DIAG_RESET;
    else
      core_diagnostic_status <= next_diag;
  end

  // ************************************************************
  // Operation control
  // ************************************************************
  // Ground short on the current-set pin latches until power cycles
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      iset_latched <= 1'b0;
    else if (iset_det)
      iset_latched <= 1'b1;
  end

  // Halt follows the live range faults so operation resumes later; a current-set short holds it until power-on reset
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      operation_halt_o <= 1'b0;
      boost_disable_o  <= 1'b0;
    end
    else
    begin
      operation_halt_o <= rt_det || reference_current_det
                          || iset_det || iset_latched;
      boost_disable_o  <= buv_det;
    end
  end

  // ************************************************************
  // Fault pin
  // ************************************************************
  // Each fault class gated by its mask bit; hard faults never masked
  assign any_unmasked =
      (|shorted_string_flags && !fault_pin_mask_a[MA_SHORTED_STRING])
    || (core_diagnostic_status[DG_THERMAL_WARN]
        && !fault_pin_mask_a[MA_THERMAL_WARN])
    || (ground_short_fault_i
        && !fault_pin_mask_a[MA_GROUND_SHORT])
    || (open_string_fault_i
        && !fault_pin_mask_a[MA_OPEN_STRING])
    || (core_diagnostic_status[DG_BOOST_LOW]
        && !fault_pin_mask_a[MA_BOOST_LOW])
    || (current_mismatch_i
        && !fault_pin_mask_b[MB_CURRENT_MISMATCH])
    || (supply_low_voltage_i
        && !fault_pin_mask_b[MB_SUPPLY_LOW])
    || (parity_error_i
        && !fault_pin_mask_b[MB_PARITY_ERROR])
    || (on_time_mismatch_i
        && !fault_pin_mask_b[MB_ON_TIME_MISMATCH])
    || core_diagnostic_status[DG_TIMING_RESISTOR]
    || core_diagnostic_status[DG_CURRENT_SET_GND]
    || core_diagnostic_status[DG_REFERENCE_RANGE]
    || core_diagnostic_status[DG_BOOST_HIGH]
    || core_diagnostic_status[DG_THERMAL_SHUTDOWN]
    || clock_error;

  // Pin is registered; the power-up bit alone does not pull it
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fault_out_n_o <= 1'b1;
    else
      fault_out_n_o <= !any_unmasked;
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Data shows the value before the read-clear of the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_SHORTED_STRING_FLAGS:
          reg_rdata_o <= 8'(shorted_string_flags);
        ADDR_FAULT_PIN_MASK_A:       reg_rdata_o <= fault_pin_mask_a;
        ADDR_FAULT_PIN_MASK_B:       reg_rdata_o <= fault_pin_mask_b;
        ADDR_CORE_DIAGNOSTIC_STATUS: reg_rdata_o <= core_diagnostic_status;
        default:                     reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_short_set_flag : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (short_det != '0) |=>
      ((shorted_string_flags & $past(short_det)) == $past(short_det)))
    else $error("shorted-string detection not flagged");

  chk_short_read_clear : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (rd_short && short_det == '0) |=> (shorted_string_flags == '0))
    else $error("shorted-string flags not cleared by read");

  chk_pin_follows_faults : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    any_unmasked |=> !fault_out_n_o)
    else $error("unmasked fault did not drive pin low");

  chk_pin_release : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !any_unmasked |=> fault_out_n_o)
    else $error("pin low with no unmasked fault");

  chk_warn_masked : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (fault_pin_mask_a[MA_THERMAL_WARN] && core_diagnostic_status == 8'h02
     && shorted_string_flags == '0 && !clock_error
     && !open_string_fault_i && !ground_short_fault_i
     && !current_mismatch_i && !supply_low_voltage_i
     && !parity_error_i && !on_time_mismatch_i) |=> fault_out_n_o)
    else $error("masked thermal warning drove pin");

  chk_boost_uv_masked : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (fault_pin_mask_a[MA_BOOST_LOW] && core_diagnostic_status == 8'h10
     && shorted_string_flags == '0 && !clock_error
     && !open_string_fault_i && !ground_short_fault_i
     && !current_mismatch_i && !supply_low_voltage_i
     && !parity_error_i && !on_time_mismatch_i) |=> fault_out_n_o)
    else $error("masked boost undervoltage drove pin");

  chk_iset_read_only : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    core_diagnostic_status[DG_CURRENT_SET_GND]
      |=> core_diagnostic_status[DG_CURRENT_SET_GND] && operation_halt_o)
    else $error("current-set fault bit or halt dropped");

  chk_power_up_clear : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    rd_diag |=> !core_diagnostic_status[DG_POWER_UP])
    else $error("power-up bit survived a read");

  chk_boost_disable : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    buv_det |=> boost_disable_o && core_diagnostic_status[DG_BOOST_LOW])
    else $error("boost undervoltage not acted on");

  chk_clock_error_pin : assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    clock_error |=> !fault_out_n_o)
    else $error("clock error did not drive pin low");

endmodule : fault_flag_mask_unit
`default_nettype wire

/* rtl/fault_flag_pkg.sv */
package fault_flag_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_SHORTED_STRING_FLAGS   = 8'h19;
  localparam logic [7:0] ADDR_FAULT_PIN_MASK_A       = 8'h1A;
  localparam logic [7:0] ADDR_FAULT_PIN_MASK_B       = 8'h1B;
  localparam logic [7:0] ADDR_CORE_DIAGNOSTIC_STATUS = 8'h1C;

  // ************************************************************
  // Field positions
  // ************************************************************
  // First mask register
  localparam int MA_SHORTED_STRING = 0;
  localparam int MA_THERMAL_WARN   = 1;
  localparam int MA_GROUND_SHORT   = 2;
  localparam int MA_OPEN_STRING    = 3;
  localparam int MA_BOOST_LOW      = 4;
  localparam logic [7:0] MASK_A_WRITABLE = 8'h1F;
  localparam logic [7:0] MASK_A_RESET    = 8'h02;

  // Second mask register, bits 3 to 0 unused
  localparam int MB_CURRENT_MISMATCH = 4;
  localparam int MB_SUPPLY_LOW       = 5;
  localparam int MB_PARITY_ERROR     = 6;
  localparam int MB_ON_TIME_MISMATCH = 7;
  localparam logic [7:0] MASK_B_WRITABLE = 8'hF0;
  localparam logic [7:0] MASK_B_RESET    = 8'h00;

  // Core diagnostic register
  localparam int DG_THERMAL_SHUTDOWN = 0;
  localparam int DG_THERMAL_WARN     = 1;
  localparam int DG_POWER_UP         = 2;
  localparam int DG_BOOST_HIGH       = 3;
  localparam int DG_BOOST_LOW        = 4;
  localparam int DG_REFERENCE_RANGE  = 5;
  localparam int DG_CURRENT_SET_GND  = 6;
  localparam int DG_TIMING_RESISTOR  = 7;
  localparam logic [7:0] DIAG_RESET      = 8'h04;
  localparam logic [7:0] SHORTED_RESET   = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int CLOCK_IDLE_TIME_NS = 1000;
  // Longest idle time, rounded down to whole cycles
  localparam int CLOCK_IDLE_CYCLES  =
    (CLOCK_IDLE_TIME_NS * 1000) / CLK_PERIOD_PS;

endpackage : fault_flag_pkg

/* testbench/host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Host controller on the register port
// ************************************************************
module host_model
  import fault_flag_pkg::*;
(
  input  wire logic       clk_i,
  output var  logic [7:0] reg_addr_o,
  output var  logic       reg_wr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  // Idle bus parked on an unmapped address
  initial
  begin
    reg_addr_o  = 8'hFF;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // One write strobe, raised and dropped on falling edges
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~data; // Stale data must not look valid
  endtask : write_reg

  // Read data is registered, so it is taken half a cycle later
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_i);
    reg_addr_o = addr;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    data       = reg_rdata_i;
  endtask : read_reg

  // First access after power-up picks up the power-up indication
  task automatic boot_read(output logic [7:0] data);
    read_reg(ADDR_CORE_DIAGNOSTIC_STATUS, data);
  endtask : boot_read
endmodule : host_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Fault flag and mask unit bench
// ************************************************************
module tb_top;
  import fault_flag_pkg::*;
  logic       clk, arst_n, wr, rd, fault_n, halt, bdis, osc_tick, osc_run;
  logic [7:0] addr, wdata, rdata, ddet, d, rdata_a;
  logic [5:0] sdet, cls, pat;
  int         fail_count, total_checks;
  int         dbits[6] = '{7, 5, 4, 3, 1, 0};

  host_model i_host_model (.clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata));

  // Short idle limit keeps the clock-loss case brief
  fault_flag_mask_unit #(.IDLE_CYCLES(8)) i_fault_flag_mask_unit (
    .clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .shorted_string_det_i(sdet), .timing_resistor_det_i(ddet[7]),
    .current_set_gnd_det_i(ddet[6]), .reference_current_det_i(ddet[5]),
    .boost_low_voltage_det_i(ddet[4]), .boost_high_voltage_det_i(ddet[3]),
    .thermal_warning_det_i(ddet[1]), .thermal_shutdown_det_i(ddet[0]),
    .osc_tick_i(osc_tick), .osc_range_det_i(1'b0),
    .open_string_fault_i(cls[0]), .ground_short_fault_i(cls[1]),
    .on_time_mismatch_i(cls[2]), .parity_error_i(cls[3]),
    .supply_low_voltage_i(cls[4]), .current_mismatch_i(cls[5]),
    .fault_out_n_o(fault_n), .operation_halt_o(halt),
    .boost_disable_o(bdis));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Oscillator activity toggles every cycle while running
  // A stopped oscillator parks low: a stuck high level reads as activity
  always @(negedge clk)
    osc_tick <= osc_run ? ~osc_tick : 1'b0;

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic conclude();
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Unmaskable diagnostic bits and unmasked classes pull the pin low
  function automatic logic [7:0] pin_for(input int b, input logic [7:0] ma);
    if (b == 4)
      return {7'h0, ma[4]};
    if (b == 1)
      return {7'h0, ma[1]};
    return 8'h00;
  endfunction : pin_for

  // Hang guard well beyond the whole sequence
  initial
  begin
    #80000;
    fail_count++;
    conclude();
  end

  initial
  begin
    {sdet, ddet, cls, osc_tick} = '0;
    osc_run = 1'b1;
    arst_n  = 1'b0;
    void'($urandom(77));
    cyc(2);
    arst_n = 1'b1;
    i_host_model.boot_read(d);
    chk("diag after reset", d, 8'h04);
    i_host_model.read_reg(ADDR_CORE_DIAGNOSTIC_STATUS, d);
    chk("diag second read", d, 8'h00);
    i_host_model.read_reg(ADDR_FAULT_PIN_MASK_A, d);
    chk("mask a reset", d, 8'h02);
    i_host_model.read_reg(ADDR_FAULT_PIN_MASK_B, d);
    chk("mask b reset", d, 8'h00);
    i_host_model.read_reg(8'h40, d);
    chk("unmapped read", d, 8'h00);
    i_host_model.write_reg(ADDR_CORE_DIAGNOSTIC_STATUS, 8'hFF);
    i_host_model.read_reg(ADDR_CORE_DIAGNOSTIC_STATUS, d);
    chk("diag after write", d, 8'h00);
    // Random mask values, reserved bits must read zero
    repeat (4)
    begin
      pat = 6'($urandom);
      d   = 8'($urandom);
      i_host_model.write_reg(ADDR_FAULT_PIN_MASK_A, d);
      i_host_model.write_reg(ADDR_FAULT_PIN_MASK_B, ~d);
      i_host_model.read_reg(ADDR_FAULT_PIN_MASK_A, rdata_a);
      chk("mask a", rdata_a, d & 8'h1F);
      i_host_model.read_reg(ADDR_FAULT_PIN_MASK_B, rdata_a);
      chk("mask b", rdata_a, ~d & 8'hF0);
    end
    i_host_model.write_reg(ADDR_FAULT_PIN_MASK_A, 8'h00);
    i_host_model.write_reg(ADDR_FAULT_PIN_MASK_B, 8'h00);
    chk("pin idle", {7'h0, fault_n}, 8'h01);
    // Same-clock classes: pin follows each one until its mask is set
    for (int i = 0; i < 6; i++)
    begin
      cls[i] = 1'b1;
      cyc(2);
      chk("class pin", {7'h0, fault_n}, 8'h00);
      i_host_model.write_reg(i < 2 ? ADDR_FAULT_PIN_MASK_A :
        ADDR_FAULT_PIN_MASK_B, 8'h01 << (i < 2 ? 3 - i : 9 - i));
      cyc(2);
      chk("class masked", {7'h0, fault_n}, 8'h01);
      i_host_model.write_reg(i < 2 ? ADDR_FAULT_PIN_MASK_A :
        ADDR_FAULT_PIN_MASK_B, 8'h00);
      cls[i] = 1'b0;
    end
    // Random channels shorted, flags latch and clear on read
    pat  = 6'($urandom_range(63, 1));
    sdet = pat;
    cyc(6);
    chk("short pin", {7'h0, fault_n}, 8'h00);
    i_host_model.write_reg(ADDR_FAULT_PIN_MASK_A, 8'h01);
    cyc(2);
    chk("short masked", {7'h0, fault_n}, 8'h01);
    sdet = '0;
    cyc(4);
    i_host_model.read_reg(ADDR_SHORTED_STRING_FLAGS, d);
    chk("short flags", d, {2'b00, pat});
    i_host_model.read_reg(ADDR_SHORTED_STRING_FLAGS, d);
    chk("short cleared", d, 8'h00);
    // Diagnostic bits one at a time, boost low and warning masked
    i_host_model.write_reg(ADDR_FAULT_PIN_MASK_A, 8'h12);
    foreach (dbits[k])
    begin
      ddet[dbits[k]] = 1'b1;
      cyc(6);
      chk("halt", {7'h0, halt}, {7'h0, dbits[k] == 7 || dbits[k] == 5});
      chk("boost off", {7'h0, bdis}, {7'h0, dbits[k] == 4});
      chk("diag pin", {7'h0, fault_n}, pin_for(dbits[k], 8'h12));
      ddet[dbits[k]] = 1'b0;
      cyc(4);
      i_host_model.read_reg(ADDR_CORE_DIAGNOSTIC_STATUS, d);
      chk("diag bit", d, 8'h01 << dbits[k]);
      i_host_model.read_reg(ADDR_CORE_DIAGNOSTIC_STATUS, d);
      chk("diag clear", d, 8'h00);
      cyc(1);
      chk("pin released", {7'h0, fault_n}, 8'h01);
    end
    // Oscillator stops: pin latches low even after it restarts
    osc_run = 1'b0;
    cyc(20);
    osc_run = 1'b1;
    cyc(10);
    chk("clock error pin", {7'h0, fault_n}, 8'h00);
    // Current-set short is read-only and halts for good
    ddet[6] = 1'b1;
    cyc(6);
    ddet[6] = 1'b0;
    cyc(4);
    i_host_model.read_reg(ADDR_CORE_DIAGNOSTIC_STATUS, d);
    i_host_model.read_reg(ADDR_CORE_DIAGNOSTIC_STATUS, d);
    chk("current set flag", d, 8'h40);
    chk("current set halt", {7'h0, halt}, 8'h01);
    // Power-on reset in mid-run clears clock error and latched halt
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(2);
    chk("pin after por", {7'h0, fault_n}, 8'h01);
    chk("halt after por", {7'h0, halt}, 8'h00);
    i_host_model.boot_read(d);
    chk("diag after por", d, 8'h04);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
